//--- hw/bypass_override_pkg.sv
package bypass_override_pkg;
  // =====================================================
  // register map (byte addresses, 32-bit words)
  localparam logic [11:0] SEC_CTRL_ADDR = 12'h000;
  localparam logic [11:0] NS_CTRL_ADDR = 12'h004;
  localparam logic [11:0] BYP_COUNT_ADDR = 12'h008;
  localparam int ADDR_W = 12;
  // =====================================================
  // field positions
  localparam int SEC_OVR_LSB = 28;
  localparam int WR_OVR_LSB = 26;
  localparam int RD_OVR_LSB = 24;
  localparam int SH_OVR_LSB = 22;
  localparam int CPD_BIT = 0;
  localparam int USF_BIT = 1;
  localparam logic [31:0] SEC_WR_MASK = 32'h3fc0_0003;
  localparam logic [31:0] NS_WR_MASK = 32'h0000_0003;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  localparam logic [31:0] NS_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // =====================================================
  // override encodings
  typedef enum logic [1:0] {
    OVR_PASS = 2'b00,
    OVR_RSVD = 2'b01,
    OVR_ON = 2'b10,
    OVR_OFF = 2'b11
  } ovr_t;
  typedef enum logic [1:0] {
    SH_OVR_PASS = 2'b00,
    SH_OVR_OUTER = 2'b01,
    SH_OVR_INNER = 2'b10,
    SH_OVR_NONE = 2'b11
  } sh_ovr_t;
  typedef enum logic [1:0] {
    SHARE_NON = 2'b00,
    SHARE_INNER = 2'b01,
    SHARE_OUTER = 2'b10,
    SHARE_RSVD = 2'b11
  } share_t;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  // =====================================================
  // client transaction attributes
  typedef struct packed {
    logic valid;
    logic prot1;
    logic matched;
    logic wr_alloc;
    logic rd_alloc;
    share_t share;
  } txn_in_t;
  typedef struct packed {
    logic valid;
    logic nonsec;
    logic wr_alloc;
    logic rd_alloc;
    share_t share;
    logic bypass;
  } txn_out_t;
endpackage

//--- hw/bypass_override.sv
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - secure control register needs secure access
// - nonsecure register governs only nonsecure transactions
// - security override field selects bypass security
// - override field absent from nonsecure register
// - security override only on bypassed secure transactions
// - write allocate override for bypassed transactions
// - read allocate override for bypassed transactions
// - shareability override for bypassed transactions
// - attribute overrides only when transaction bypasses
module bypass_override (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic I_HNONSEC,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic [31:0] O_HRDATA,
  output logic O_HRESP,
  input wire bypass_override_pkg::txn_in_t I_TXN,
  output bypass_override_pkg::txn_out_t O_TXN
);
  import bypass_override_pkg::*;

  // =====================================================
  // bus slave
  logic ap_take;
  logic dp_valid_reg;
  logic dp_write_reg;
  logic dp_nonsec_reg;
  logic [ADDR_W-1:0] dp_addr_reg;
  logic [31:0] sec_reg;
  logic [31:0] sec_next;
  logic [31:0] ns_reg;
  logic [31:0] ns_next;
  logic [15:0] count_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_value;
  logic dp_wr;

  assign ap_take = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign dp_wr = dp_valid_reg & dp_write_reg;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_HRDATA = hrdata_reg;

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_nonsec_reg <= 1'b1;
      dp_addr_reg <= '0;
    end else begin
      dp_valid_reg <= ap_take;
      dp_write_reg <= ap_take & I_HWRITE;
      dp_nonsec_reg <= I_HNONSEC;
      dp_addr_reg <= I_HADDR[ADDR_W-1:0];
    end
  end

  // nonsecure writes to the secure word are silently dropped
  always_comb begin
    sec_next = sec_reg;
    ns_next = ns_reg;
    if (dp_wr && !dp_nonsec_reg && dp_addr_reg == SEC_CTRL_ADDR) begin
      sec_next = I_HWDATA & SEC_WR_MASK;
    end
    if (dp_wr && dp_addr_reg == NS_CTRL_ADDR) begin
      ns_next = I_HWDATA & NS_WR_MASK;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      sec_reg <= SEC_RESET;
      ns_reg <= NS_RESET;
    end else begin
      sec_reg <= sec_next;
      ns_reg <= ns_next;
    end
  end

  // read from next values so a read right after a write sees it
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (I_HADDR[ADDR_W-1:0])
      SEC_CTRL_ADDR: rd_value = I_HNONSEC ? 32'h0000_0000 : sec_next;
      NS_CTRL_ADDR: rd_value = ns_next;
      BYP_COUNT_ADDR: rd_value = {16'h0000, count_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (ap_take && !I_HWRITE) begin
      hrdata_reg <= rd_value;
    end else begin
      hrdata_reg <= 32'h0000_0000;
    end
  end

  // =====================================================
  // bypass decision and attribute override
  logic txn_secure;
  logic s_bypass;
  logic ns_bypass;
  logic bypass;
  ovr_t sec_ovr;
  ovr_t wr_ovr;
  ovr_t rd_ovr;
  sh_ovr_t sh_ovr;
  txn_out_t txn_next;

  assign sec_ovr = ovr_t'(sec_reg[SEC_OVR_LSB +: 2]);
  assign wr_ovr = ovr_t'(sec_reg[WR_OVR_LSB +: 2]);
  assign rd_ovr = ovr_t'(sec_reg[RD_OVR_LSB +: 2]);
  assign sh_ovr = sh_ovr_t'(sec_reg[SH_OVR_LSB +: 2]);
  assign txn_secure = ~I_TXN.prot1;
  assign s_bypass = sec_reg[CPD_BIT] |
                    (~I_TXN.matched & ~sec_reg[USF_BIT]);
  assign ns_bypass = ns_reg[CPD_BIT] |
                     (~I_TXN.matched & ~ns_reg[USF_BIT]);
  // each world's bypass decision comes from its own register only
  assign bypass = txn_secure ? s_bypass : ns_bypass;

  // reserved encodings pass the presented attribute through
  always_comb begin
    txn_next.valid = I_TXN.valid;
    txn_next.bypass = bypass;
    txn_next.nonsec = I_TXN.prot1;
    txn_next.wr_alloc = I_TXN.wr_alloc;
    txn_next.rd_alloc = I_TXN.rd_alloc;
    txn_next.share = I_TXN.share;
    if (txn_secure && s_bypass) begin
      unique case (sec_ovr)
        OVR_ON: txn_next.nonsec = 1'b0;
        OVR_OFF: txn_next.nonsec = 1'b1;
        default: txn_next.nonsec = I_TXN.prot1;
      endcase
    end
    if (bypass) begin
      unique case (wr_ovr)
        OVR_ON: txn_next.wr_alloc = 1'b1;
        OVR_OFF: txn_next.wr_alloc = 1'b0;
        default: txn_next.wr_alloc = I_TXN.wr_alloc;
      endcase
      unique case (rd_ovr)
        OVR_ON: txn_next.rd_alloc = 1'b1;
        OVR_OFF: txn_next.rd_alloc = 1'b0;
        default: txn_next.rd_alloc = I_TXN.rd_alloc;
      endcase
      unique case (sh_ovr)
        SH_OVR_OUTER: txn_next.share = SHARE_OUTER;
        SH_OVR_INNER: txn_next.share = SHARE_INNER;
        SH_OVR_NONE: txn_next.share = SHARE_NON;
        default: txn_next.share = I_TXN.share;
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_TXN <= '0;
    end else begin
      O_TXN <= txn_next;
    end
  end

  // saturating so software never sees a wrap to zero
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      count_reg <= COUNT_RESET;
    end else if (I_TXN.valid && bypass && count_reg != 16'hffff) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // =====================================================
  // assertions
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  a_sec_write_blocked: assert property (
    dp_wr && dp_nonsec_reg && dp_addr_reg == SEC_CTRL_ADDR
    |=> $stable(sec_reg))
    else $error("nonsecure write changed secure control");

  a_sec_write_taken: assert property (
    dp_wr && !dp_nonsec_reg && dp_addr_reg == SEC_CTRL_ADDR
    |=> sec_reg == ($past(I_HWDATA) & SEC_WR_MASK))
    else $error("secure write not stored as masked");

  a_ns_read_blank: assert property (
    ap_take && !I_HWRITE && I_HNONSEC
    && I_HADDR[ADDR_W-1:0] == SEC_CTRL_ADDR
    |=> O_HRDATA == 32'h0000_0000)
    else $error("nonsecure read saw secure control");

  a_ns_field_empty: assert property (
    ns_reg[SEC_OVR_LSB +: 2] == 2'b00)
    else $error("security override bits held in nonsecure word");

  a_force_secure: assert property (
    I_TXN.valid && txn_secure && s_bypass && sec_ovr == OVR_ON
    |=> O_TXN.valid && !O_TXN.nonsec)
    else $error("bypassed secure transaction not forced secure");

  a_force_nonsec: assert property (
    I_TXN.valid && txn_secure && s_bypass && sec_ovr == OVR_OFF
    |=> O_TXN.nonsec)
    else $error("bypassed secure transaction not forced nonsecure");

  a_ns_stays_ns: assert property (
    I_TXN.valid && I_TXN.prot1 |=> O_TXN.nonsec)
    else $error("nonsecure transaction turned secure");

  a_mapped_untouched: assert property (
    I_TXN.valid && !bypass
    |=> O_TXN.wr_alloc == $past(I_TXN.wr_alloc)
        && O_TXN.rd_alloc == $past(I_TXN.rd_alloc)
        && O_TXN.share == $past(I_TXN.share)
        && O_TXN.nonsec == $past(I_TXN.prot1))
    else $error("mapped transaction attributes altered");

  a_write_alloc: assert property (
    I_TXN.valid && bypass && wr_ovr == OVR_ON |=> O_TXN.wr_alloc)
    else $error("write allocate not forced");

  a_read_noalloc: assert property (
    I_TXN.valid && bypass && rd_ovr == OVR_OFF |=> !O_TXN.rd_alloc)
    else $error("read no-allocate not forced");

  a_share_outer: assert property (
    I_TXN.valid && bypass && sh_ovr == SH_OVR_OUTER
    |=> O_TXN.share == SHARE_OUTER)
    else $error("outer shareable not forced");

  c_sec_forced: cover property (
    I_TXN.valid && txn_secure && s_bypass && sec_ovr == OVR_OFF);
  c_ns_bypass: cover property (I_TXN.valid && !txn_secure && ns_bypass);
  c_write_then_read: cover property (
    dp_wr && ap_take && !I_HWRITE);
  c_blocked_write: cover property (
    dp_wr && dp_nonsec_reg && dp_addr_reg == SEC_CTRL_ADDR);

endmodule

//--- verification/client_model.sv
`timescale 1ns/1ps
// ==========
// client master, one transaction per call
module client_model (
  input wire logic i_clk,
  output bypass_override_pkg::txn_in_t o_txn
);
  import bypass_override_pkg::*;
  initial o_txn = '0;
  // released lines invert, so stale attributes cannot pass unseen
  task automatic send(input txn_in_t t);
    @(posedge i_clk);
    o_txn <= t;
    @(posedge i_clk);
    o_txn <= {1'b0, ~t[5:0]};
  endtask
endmodule

//--- verification/tb_bypass_override.sv
`timescale 1ns/1ps
module tb_bypass_override;
  import bypass_override_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic hnonsec = 0;
  logic hready;
  logic hresp;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic resp;
  txn_in_t txn;
  txn_out_t tout;
  int fails = 0;
  int tests_run = 0;
  int nbyp = 0;
  always #2 clk = ~clk;
  bypass_override bypass_override_i (.I_MCLK(clk), .I_RST_N(rst_n),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HNONSEC(hnonsec), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRDATA(hrdata),
    .O_HRESP(hresp), .I_TXN(txn), .O_TXN(tout));
  client_model client_model_i (.i_clk(clk), .o_txn(txn));
  // ==========
  // reporting
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // ==========
  // bus master
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic w, input logic ns, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hnonsec <= ns;
    haddr <= {20'h0, a};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    // data phase ends at this edge: take data and response now
    rd = hrdata;
    resp = hresp;
    hsel <= 1'b0;
  endtask
  // ==========
  // expected attributes of one transaction
  function automatic txn_out_t exp_txn(input logic [31:0] sw,
      input logic [31:0] nw, input txn_in_t t);
    logic [31:0] w;
    txn_out_t o;
    w = t.prot1 ? nw : sw;
    o = {1'b1, t.prot1, t.wr_alloc, t.rd_alloc, t.share, 1'b0};
    o.bypass = w[CPD_BIT] | (~t.matched & ~w[USF_BIT]);
    if (o.bypass) begin
      if (!t.prot1 && sw[29]) o.nonsec = sw[28];
      if (sw[27]) o.wr_alloc = ~sw[26];
      if (sw[25]) o.rd_alloc = ~sw[24];
      case (sw[23:22])
        2'b01: o.share = SHARE_OUTER;
        2'b10: o.share = SHARE_INNER;
        2'b11: o.share = SHARE_NON;
        default: ;
      endcase
    end
    return o;
  endfunction
  // ==========
  // main sequence
  initial begin
    logic [31:0] s;
    logic [31:0] n;
    logic [31:0] d;
    txn_in_t t;
    txn_out_t e;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 0, SEC_CTRL_ADDR, 0, d);
    chk(d, SEC_RESET);
    bus(0, 1, NS_CTRL_ADDR, 0, d);
    chk(d, NS_RESET);
    bus(1, 0, SEC_CTRL_ADDR, 32'hffff_ffff, d);
    bus(0, 0, SEC_CTRL_ADDR, 0, d);
    chk(d, 32'h3fc0_0003);
    bus(0, 1, SEC_CTRL_ADDR, 0, d);
    chk(d, 32'h0000_0000);
    bus(1, 1, SEC_CTRL_ADDR, 32'h0000_0000, d);
    chk({31'h0, resp}, 32'h0000_0000);
    bus(0, 0, SEC_CTRL_ADDR, 0, d);
    chk(d, 32'h3fc0_0003);
    bus(1, 1, NS_CTRL_ADDR, 32'hffff_ffff, d);
    bus(0, 1, NS_CTRL_ADDR, 0, d);
    chk(d, 32'h0000_0003);
    bus(0, 0, 12'h00c, 0, d);
    chk(d, 32'h0000_0000);
    $display("register tests done");
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 4; c++) begin
        s = {2'b00, {4{k[1:0]}}, 20'h0, c[1:0]};
        n = {30'h0, ~c[1:0]};
        bus(1, 0, SEC_CTRL_ADDR, s, d);
        bus(1, 1, NS_CTRL_ADDR, n, d);
        for (int p = 0; p < 8; p++) begin
          t = {1'b1, p[0], p[1], p[2], ~p[2], share_t'(p[1:0] ^ c[1:0])};
          client_model_i.send(t);
          #1;
          e = exp_txn(s, n, t);
          if (e.bypass) nbyp++;
          chk({31'h0, tout.nonsec}, {31'h0, e.nonsec});
          chk({30'h0, tout[4:3]}, {30'h0, e[4:3]});
          chk({30'h0, tout.share}, {30'h0, e.share});
          chk({25'h0, tout}, {25'h0, e});
        end
      end
    end
    bus(0, 0, BYP_COUNT_ADDR, 0, d);
    chk(d, nbyp);
    $display("transaction tests done");
    end_of_test();
  end
endmodule
